//--- hdl/zxd_regs.vh
// Register map, field positions and reset values of the zero-cross unit
`ifndef ZXD_REGS_VH
`define ZXD_REGS_VH

// Register indexes; byte address is four times the index
`define ZXD_CTRL_IDX 16'h091f
`define ZXD_FLAG_IDX 16'h0920
`define ZXD_PMD_IDX 16'h0921

// Byte addresses on the bus
`define ZXD_CTRL_ADDR 32'h0000247c
`define ZXD_FLAG_ADDR 32'h00002480
`define ZXD_PMD_ADDR 32'h00002484

// Control register fields
`define ZXD_SEN_BIT 7
`define ZXD_OUT_BIT 5
`define ZXD_POL_BIT 4
`define ZXD_RISE_BIT 1
`define ZXD_FALL_BIT 0

// Flag register and module disable register fields
`define ZXD_FLAG_BIT 0
`define ZXD_OFF_BIT 0

// Reset values
`define ZXD_SEN_RST 1'h0
`define ZXD_POL_RST 1'h0
`define ZXD_RISE_RST 1'h0
`define ZXD_FALL_RST 1'h0
`define ZXD_OUT_RST 1'h0
`define ZXD_FLAG_RST 1'h0
`define ZXD_OFF_RST 1'h0

// AHB transfer type and response codes
`define ZXD_HTRANS_NONSEQ 2'h2
`define ZXD_HRESP_OKAY 1'h0

`endif

//--- hdl/zxd_sync.v
// Two-stage synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ns
`default_nettype none

module zxd_sync #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // Asynchronous levels in
   input wire [WIDTH-1:0] async_in,
   // Synchronised levels out
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] stable_r;

   // First stage feeds only the second stage
   always @(posedge clock) begin
      if (!rst_n) begin
         meta_r <= {WIDTH{1'b0}};
         stable_r <= {WIDTH{1'b0}};
      end else begin
         meta_r <= async_in;
         stable_r <= meta_r;
      end
   end

   assign sync_out = stable_r;

endmodule

`default_nettype wire

//--- hdl/zxd_ctrl.v
// Zero-cross unit control logic with AHB-Lite register slave
//
// Summary of operation
// - Fuse zero keeps detector always on
// - Fuse one, enable set: pin drives current
// - Fuse one, enable clear: normal pin routing
// - Output bit reads sink one, polarity adjusted
// - Polarity bit inverts logic output everywhere
// - Rising enable: rising edge sets flag
// - Falling enable: falling edge sets flag
// - Operation continues unchanged during sleep
// - Module disable bit off, fuse has precedence
// - Polarity change raises an interrupt event
// - Software clears flag; coincident edge wins
//
// Register map, one word each, data in bits 7:0
//   control: enable 7, output 5 (read only), polarity 4, edge enables 1:0
//   flag: bit 0, writing a one clears it, a set in the same cycle wins
//   module disable: bit 0, overridden while the fuse reads clear
// The unit stays off for two edges after reset while the fuse level settles,
// so the reset value of the synchroniser can never switch the pin briefly on
`timescale 1ns/1ns
`default_nettype none
`include "zxd_regs.vh"

module zxd_ctrl #(
   parameter ADDR_WIDTH = 32
) (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // AHB-Lite slave
   input wire hsel,
   input wire [ADDR_WIDTH-1:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // Analog front end and configuration fuse
   input wire cmp_sink_active,
   input wire cfg_fuse,
   // Pin function and logic output
   output reg pin_current_mode,
   output reg pin_normal_mode,
   output reg zero_cross_out,
   // Interrupt flag level
   output reg crossing_irq_flag
);

   // Control register fields
   reg sw_enable_bit_r;
   reg output_invert_bit_r;
   reg rise_irq_enable_r;
   reg fall_irq_enable_r;
   reg module_off_bit_r;
   reg out_bit_r;
   reg prev_out_r;
   reg active_r;

   // Settle count after reset
   reg [1:0] settle_r;
   wire settled;

   // Captured address phase
   reg wr_pend_r;
   reg [ADDR_WIDTH-1:0] wr_addr_r;

   // Synchronised inputs
   wire [1:0] sync_levels;
   wire sink_sync;
   wire fuse_sync;

   // Decoded bus events
   wire addr_phase;
   wire wr_ctrl;
   wire wr_flag;
   wire wr_pmd;
   wire fuse_forces_on;
   wire sw_request;
   wire enable_nxt;
   wire logic_nxt;
   wire rise_event;
   wire fall_event;
   wire pol_event;
   wire flag_clear;
   wire flag_set;
   reg [31:0] rd_nxt;

   // Comparator and fuse pass two flops before any logic
   zxd_sync #(
      .WIDTH(2)
   ) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .async_in({cfg_fuse, cmp_sink_active}),
      .sync_out(sync_levels)
   );

   assign sink_sync = sync_levels[0];
   assign fuse_sync = sync_levels[1];

   // Zero-wait slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = `ZXD_HRESP_OKAY;

   // Address phase of a valid NONSEQ or SEQ transfer
   assign addr_phase = hsel & htrans[1] & hready;

   // Write strobes in the data phase
   assign wr_ctrl = wr_pend_r & (wr_addr_r == `ZXD_CTRL_ADDR);
   assign wr_flag = wr_pend_r & (wr_addr_r == `ZXD_FLAG_ADDR);
   assign wr_pmd = wr_pend_r & (wr_addr_r == `ZXD_PMD_ADDR);

   // Fuse clear forces the unit on; module disable only acts under a set fuse
   assign fuse_forces_on = ~fuse_sync;
   assign sw_request = sw_enable_bit_r & ~module_off_bit_r;

   // Enable waits until the synchroniser holds real levels
   assign enable_nxt = settled & (fuse_forces_on | sw_request);

   // Two edges fill both synchroniser stages
   assign settled = settle_r[1];

   // Settle count; stops once both stages hold sampled levels
   always @(posedge clock) begin
      if (!rst_n) begin
         settle_r <= 2'h0;
      end else if (!settled) begin
         settle_r <= settle_r + 2'h1;
      end
   end

   // Polarity applied to the synchronised sink indication
   assign logic_nxt = sink_sync ^ output_invert_bit_r;

   // Edge detectors on the polarity-adjusted output, no sleep gating
   assign rise_event = active_r & ~prev_out_r & out_bit_r & rise_irq_enable_r;
   assign fall_event = active_r & prev_out_r & ~out_bit_r & fall_irq_enable_r;

   // A write that changes polarity raises an event whatever the enable
   assign pol_event = wr_ctrl & (hwdata[`ZXD_POL_BIT] != output_invert_bit_r);

   // Flag is cleared by writing one to its bit
   assign flag_clear = wr_flag & hwdata[`ZXD_FLAG_BIT];
   assign flag_set = rise_event | fall_event | pol_event;

   // Capture of the address phase for writes
   always @(posedge clock) begin
      if (!rst_n) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= {ADDR_WIDTH{1'b0}};
      end else begin
         wr_pend_r <= addr_phase & hwrite;
         if (addr_phase) begin
            wr_addr_r <= haddr;
         end
      end
   end

   // Software-written control fields
   always @(posedge clock) begin
      if (!rst_n) begin
         sw_enable_bit_r <= `ZXD_SEN_RST;
         output_invert_bit_r <= `ZXD_POL_RST;
         rise_irq_enable_r <= `ZXD_RISE_RST;
         fall_irq_enable_r <= `ZXD_FALL_RST;
      end else if (wr_ctrl) begin
         sw_enable_bit_r <= hwdata[`ZXD_SEN_BIT];
         output_invert_bit_r <= hwdata[`ZXD_POL_BIT];
         rise_irq_enable_r <= hwdata[`ZXD_RISE_BIT];
         fall_irq_enable_r <= hwdata[`ZXD_FALL_BIT];
      end
   end

   // Peripheral module disable bit
   always @(posedge clock) begin
      if (!rst_n) begin
         module_off_bit_r <= `ZXD_OFF_RST;
      end else if (wr_pmd) begin
         module_off_bit_r <= hwdata[`ZXD_OFF_BIT];
      end
   end

   // Enable state seen by the output and edge logic
   always @(posedge clock) begin
      if (!rst_n) begin
         active_r <= 1'b0;
      end else begin
         active_r <= enable_nxt;
      end
   end

   // Pin function select; normal routing whenever the unit is off
   always @(posedge clock) begin
      if (!rst_n) begin
         pin_current_mode <= 1'b0;
         pin_normal_mode <= 1'b1;
      end else begin
         pin_current_mode <= enable_nxt;
         pin_normal_mode <= ~enable_nxt;
      end
   end

   // Logic output and its previous value for edge detection
   always @(posedge clock) begin
      if (!rst_n) begin
         out_bit_r <= `ZXD_OUT_RST;
         prev_out_r <= `ZXD_OUT_RST;
      end else if (active_r) begin
         out_bit_r <= logic_nxt;
         prev_out_r <= out_bit_r;
      end else begin
         prev_out_r <= out_bit_r;
      end
   end

   // Output seen by other modules tracks the out bit while enabled
   always @(posedge clock) begin
      if (!rst_n) begin
         zero_cross_out <= `ZXD_OUT_RST;
      end else if (active_r) begin
         zero_cross_out <= logic_nxt;
      end
   end

   // Interrupt flag; a set in the clearing cycle wins
   always @(posedge clock) begin
      if (!rst_n) begin
         crossing_irq_flag <= `ZXD_FLAG_RST;
      end else if (flag_set) begin
         crossing_irq_flag <= 1'b1;
      end else if (flag_clear) begin
         crossing_irq_flag <= 1'b0;
      end
   end

   // Read mux; unmapped addresses read zero
   always @* begin
      rd_nxt = 32'h00000000;
      if (haddr == `ZXD_CTRL_ADDR) begin
         rd_nxt[`ZXD_SEN_BIT] = sw_enable_bit_r;
         rd_nxt[`ZXD_OUT_BIT] = out_bit_r;
         rd_nxt[`ZXD_POL_BIT] = output_invert_bit_r;
         rd_nxt[`ZXD_RISE_BIT] = rise_irq_enable_r;
         rd_nxt[`ZXD_FALL_BIT] = fall_irq_enable_r;
      end else if (haddr == `ZXD_FLAG_ADDR) begin
         rd_nxt[`ZXD_FLAG_BIT] = crossing_irq_flag;
      end else if (haddr == `ZXD_PMD_ADDR) begin
         rd_nxt[`ZXD_OFF_BIT] = module_off_bit_r;
      end
   end

   // Read data registered at the address phase
   always @(posedge clock) begin
      if (!rst_n) begin
         hrdata <= 32'h00000000;
      end else if (addr_phase & ~hwrite) begin
         hrdata <= rd_nxt;
      end
   end

endmodule

`default_nettype wire

//--- bench/zxd_wave.sv
// Behavioural AC source seen through the series resistor
`timescale 1ns/1ns
`default_nettype none
module zxd_wave (
   // Clock
   input wire logic clock,
   // Requested level and lag in cycles
   input wire logic level_req,
   input wire logic [2:0] lag,
   // Comparator level, high while the pin sinks
   output wire logic cmp_sink_active
);
   logic [7:0] pipe_r = 8'h00;
   // Delay line lets the source answer promptly or slowly
   always @(posedge clock) begin
      pipe_r <= {pipe_r[6:0], level_req};
   end
   assign cmp_sink_active = pipe_r[lag];
endmodule
`default_nettype wire

//--- bench/zxd_ctrl_monitor.sv
// Checker of bus answers, pin function and flag timing
`timescale 1ns/1ns
`default_nettype none
`include "zxd_regs.vh"
module zxd_ctrl_monitor (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // Bus
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata,
   // Unit
   input wire cmp_sink_active,
   input wire cfg_fuse,
   input wire pin_current_mode,
   input wire pin_normal_mode,
   input wire zero_cross_out,
   input wire crossing_irq_flag
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Bus always ready with an okay answer
   resp_okay_a: assert property (hreadyout && !hresp)
      else $error("bus answer not ready and okay");
   pin_compl_a: assert property (pin_normal_mode == !pin_current_mode)
      else $error("pin functions not complementary");
   fuse_on_a: assert property (!cfg_fuse [*5] |-> pin_current_mode)
      else $error("fuse zero left unit off");
   out_follow_a: assert property ($changed(cmp_sink_active) && pin_current_mode
      |-> ##[1:4] $changed(zero_cross_out)) else $error("output missed a crossing");
   flag_clear_a: assert property ($fell(crossing_irq_flag) |->
      $past(hsel && hwrite && htrans[1] && haddr == `ZXD_FLAG_ADDR, 2))
      else $error("flag cleared without a write");
   flag_cause_a: assert property ($rose(crossing_irq_flag) |->
      $past(zero_cross_out) != $past(zero_cross_out, 2)
      || $past(hsel && hwrite && htrans[1], 2)) else $error("flag set without cause");
   rd_out_a: assert property ($past(hsel && !hwrite && htrans[1]
      && haddr == `ZXD_CTRL_ADDR) |-> hrdata[5] == $past(zero_cross_out))
      else $error("read output bit differs");
   rd_upper_a: assert property ($past(hsel && !hwrite && htrans[1])
      |-> hrdata[31:8] == 24'h000000) else $error("upper read bits set");
endmodule
bind zxd_ctrl zxd_ctrl_monitor zxd_ctrl_monitor_i (.clock, .rst_n, .hsel, .haddr,
   .htrans, .hwrite, .hreadyout, .hresp, .hrdata, .cmp_sink_active, .cfg_fuse,
   .pin_current_mode, .pin_normal_mode, .zero_cross_out, .crossing_irq_flag);
`default_nettype wire

//--- bench/zero_cross_detect_control_tb.sv
// Self-checking bench of the zero-cross control block
`timescale 1ns/1ns
`default_nettype none
`include "zxd_regs.vh"
module zero_cross_detect_control_tb;
   logic clock, rst_n, hsel, hwrite, cfg_fuse, level_req;
   logic [31:0] haddr, hwdata, r;
   logic [1:0] htrans;
   logic [2:0] lag;
   wire logic hready, hresp, cmp, pin_cur, pin_norm, zco, flag;
   wire logic [31:0] hrdata;
   int error_cnt = 0;
   int samples_checked = 0;
   zxd_ctrl zxd_ctrl_i (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .cmp_sink_active(cmp),
      .cfg_fuse(cfg_fuse), .pin_current_mode(pin_cur), .pin_normal_mode(pin_norm),
      .zero_cross_out(zco), .crossing_irq_flag(flag));
   zxd_wave zxd_wave_i (.clock(clock), .level_req(level_req), .lag(lag),
      .cmp_sink_active(cmp));
   // Clock
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= `ZXD_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do @(posedge clock); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000);
      check(what, r, exp);
   endtask
   task wait_n(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task lvl(input logic v);
      @(posedge clock);
      level_req <= v;
      wait_n(14);
   endtask
   task t_reset;
      rd_chk("ctrl", `ZXD_CTRL_ADDR, 32'h00000000);
      rd_chk("flag", `ZXD_FLAG_ADDR, 32'h00000000);
      rd_chk("pmd", `ZXD_PMD_ADDR, 32'h00000000);
      rd_chk("unmapped", 32'h00000000, 32'h00000000);
      check("normal", pin_norm, 1'b1);
      check("current", pin_cur, 1'b0);
      check("resp", hresp, 1'b0);
      $display("test reset done");
   endtask
   task t_enable;
      bus(1'b1, `ZXD_CTRL_ADDR, 32'h00000080);
      wait_n(5);
      check("current", pin_cur, 1'b1);
      bus(1'b1, `ZXD_PMD_ADDR, 32'h00000001);
      wait_n(5);
      check("current off", pin_cur, 1'b0);
      check("normal", pin_norm, 1'b1);
      @(posedge clock);
      cfg_fuse <= 1'b0;
      wait_n(6);
      check("fuse wins", pin_cur, 1'b1);
      bus(1'b1, `ZXD_CTRL_ADDR, 32'h00000000);
      bus(1'b1, `ZXD_PMD_ADDR, 32'h00000000);
      wait_n(5);
      check("sw ignored", pin_cur, 1'b1);
      $display("test enable done");
   endtask
   task t_edges;
      bus(1'b1, `ZXD_CTRL_ADDR, 32'h00000002);
      lvl(1'b1);
      check("rise flag", flag, 1'b1);
      check("out", zco, 1'b1);
      rd_chk("out bit", `ZXD_CTRL_ADDR, 32'h00000022);
      bus(1'b1, `ZXD_FLAG_ADDR, 32'h00000001);
      rd_chk("cleared", `ZXD_FLAG_ADDR, 32'h00000000);
      lag <= 3'h5;
      lvl(1'b0);
      check("fall off", flag, 1'b0);
      bus(1'b1, `ZXD_CTRL_ADDR, 32'h00000001);
      lvl(1'b1);
      check("rise off", flag, 1'b0);
      lvl(1'b0);
      check("fall flag", flag, 1'b1);
      $display("test edges done");
   endtask
   task t_pol;
      bus(1'b1, `ZXD_FLAG_ADDR, 32'h00000001);
      bus(1'b1, `ZXD_CTRL_ADDR, 32'h00000010);
      wait_n(6);
      check("pol flag", flag, 1'b1);
      check("inverted", zco, 1'b1);
      rd_chk("pol out", `ZXD_CTRL_ADDR, 32'h00000030);
      $display("test polarity done");
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      #200000;
      error_cnt++;
      give_verdict;
   end
   // Main sequence
   initial begin
      {rst_n, hsel, hwrite, level_req, htrans, lag} = '0;
      {haddr, hwdata, cfg_fuse} = {64'h0, 1'b1};
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      t_reset;
      t_enable;
      t_edges;
      t_pol;
      give_verdict;
   end
endmodule
`default_nettype wire
